// [sclk_divider.sv]
// half-period tick generator for the serial clock
module sclk_divider #(
	parameter int SEL_W = sync_serial_pkg::DIV_SEL_W,
	parameter int CNT_W = sync_serial_pkg::DIV_CNT_W
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic run,
	input wire logic [SEL_W-1:0] div_sel,
	output logic half_tick
);

	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] last_cnt;

	// divide by 2,4,8,16 means a half period of 1,2,4,8 cycles
	assign last_cnt = CNT_W'((sync_serial_pkg::DIV_CNT_ONE << div_sel) - sync_serial_pkg::DIV_CNT_ONE);
	assign half_tick = run && (cnt_q == last_cnt);

	// counter restarts whenever the port stops, so the first half period is full length
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			cnt_q <= sync_serial_pkg::DIV_CNT_ZERO;
		end else if (!run || half_tick) begin
			cnt_q <= sync_serial_pkg::DIV_CNT_ZERO;
		end else begin
			cnt_q <= CNT_W'(cnt_q + sync_serial_pkg::DIV_CNT_ONE);
		end
	end

endmodule

// [serial_peer.sv]
// serial peripheral model: listens on the data line and answers with a byte, lsb first
module serial_peer (
	input wire logic sclk,
	input wire logic sel,
	input wire logic port_oe_n,
	input wire logic port_out,
	input wire logic [7:0] reply,
	output logic line,
	output logic [7:0] heard
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] idx = 3'h0;
	logic last = 1'b0;
	initial heard = 8'h00;
	// an undriven line shows the inverse of its last level so stale data never passes
	always_comb begin
		if (!port_oe_n) line = port_out;
		else if (sel) line = reply[idx];
		else line = ~last;
	end
	always @(posedge sclk) begin
		heard <= {line, heard[7:1]};
		last <= line;
	end
	always @(negedge sclk or negedge sel) begin
		if (!sel) idx <= 3'h0;
		else idx <= idx + 3'h1;
	end
endmodule

// [sync_serial_pkg.sv]
// constants, register map and types shared by the synchronous serial port
package sync_serial_pkg;

	// ==========================================================
	// bus geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam int BYTE_W = 8;

	// ==========================================================
	// register offsets
	localparam logic [ADDR_W-1:0] OFS_SERIAL_PORT_STATUS = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_SERIAL_PORT_CONTROL = 8'h12;
	localparam logic [ADDR_W-1:0] OFS_SERIAL_TRANSMIT_B = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_SERIAL_TRANSMIT_A = 8'h16;
	localparam logic [ADDR_W-1:0] OFS_SERIAL_RECEIVE = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h1a;
	localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 8'h1c;

	// ==========================================================
	// control register fields
	localparam int CTRL_ENABLE_A_BIT = 0;
	localparam int CTRL_ENABLE_B_BIT = 1;
	localparam int CTRL_DIV_LSB = 4;
	localparam int DIV_SEL_W = 2;
	localparam logic [DATA_W-1:0] CTRL_WRITE_MASK = 16'h0033;
	localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0000;

	// ==========================================================
	// status register fields
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_COMPLETE_BIT = 1;
	localparam int STAT_ERROR_BIT = 2;

	// ==========================================================
	// interrupt status and enable fields
	localparam int IRQ_COMPLETE_BIT = 0;
	localparam int IRQ_ERROR_BIT = 1;
	localparam int IRQ_W = 2;
	localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

	// ==========================================================
	// serial clock divider: half period in sys_clk cycles is 1 << select
	localparam int DIV_CNT_W = 3;
	localparam logic [DIV_CNT_W-1:0] DIV_CNT_ONE = 3'h1;
	localparam logic [DIV_CNT_W-1:0] DIV_CNT_ZERO = 3'h0;

	// ==========================================================
	// bit counter
	localparam int BIT_CNT_W = 4;
	localparam logic [BIT_CNT_W-1:0] BIT_CNT_ZERO = 4'h0;
	localparam logic [BIT_CNT_W-1:0] BIT_CNT_ONE = 4'h1;
	localparam logic [BIT_CNT_W-1:0] BIT_CNT_LAST = 4'h7;
	localparam logic [BIT_CNT_W-1:0] BIT_CNT_DONE = 4'h8;

	// ==========================================================
	// transfer state machine
	typedef enum logic [1:0] {
		st_idle = 2'b01,
		st_shift = 2'b10
	} xfer_state_t;

endpackage

// [sync_serial_port.sv]
// synchronous serial port: registers, enables, serial engine, status and interrupt
//
// What this block does
// [R1] the serial clock is the processor clock divided by 2, 4, 8 or 16 as the two-bit divider field selects.
// [R2] the second enable output is high while control bit 1 is set and control bit 0 is clear, and low otherwise.
// [R3] the first enable output is high while control bit 0 is set and low while it is clear.
// [R4] with both enable bits set only the first enable output goes high and the second stays low.
// [R5] the status register is read-only and writes to it change nothing.
// [R6] reading the receive register or writing a transmit register while busy with an enable bit set sets the error flag in status bit 2.
// [R7] the error flag is cleared whenever both enable control bits are zero.
// [R8] the completion flag in status bit 1 is set on the serial clock rising edge that ends data bit 7.
// [R9] reading the receive register or writing a transmit register clears the completion flag unless a transfer sets it in that same cycle.
// [R10] reading the status register clears the completion flag unless a transfer sets it in that same cycle.
// [R11] the completion flag is cleared when both enable outputs become inactive.
// [R12] the busy flag in status bit 0 is one while a transfer is in progress.
// [R13] the busy flag is zero whenever the port is idle and ready for a new transfer.
// [R14] the received byte sits in the low eight bits of the receive register and the upper bits read zero.
// [R15] two transmit registers each hold in their low eight bits a byte to be shifted out.
// [R16] a transmit write or receive read with an enable active and the port idle starts an eight-bit transfer.
module sync_serial_port #(
	parameter int BITS = sync_serial_pkg::BYTE_W
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic [sync_serial_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [sync_serial_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [sync_serial_pkg::DATA_W-1:0] reg_rdata,
	output logic serial_clock_out,
	output logic serial_enable_a_out,
	output logic serial_enable_b_out,
	input wire logic serial_data_line_in,
	output logic serial_data_line_out,
	output logic serial_data_line_oe_n,
	output logic irq
);

	// ==========================================================
	// register access decode
	logic wr_ctrl;
	logic rd_status;
	logic wr_tx_a;
	logic wr_tx_b;
	logic rd_rx;
	logic wr_irq_en;
	logic rd_irq_stat;
	logic tx_write;
	logic data_access;

	assign wr_ctrl = reg_wr && (reg_addr == sync_serial_pkg::OFS_SERIAL_PORT_CONTROL);
	assign wr_tx_a = reg_wr && (reg_addr == sync_serial_pkg::OFS_SERIAL_TRANSMIT_A);
	assign wr_tx_b = reg_wr && (reg_addr == sync_serial_pkg::OFS_SERIAL_TRANSMIT_B);
	assign wr_irq_en = reg_wr && (reg_addr == sync_serial_pkg::OFS_IRQ_ENABLE);
	assign rd_status = reg_rd && (reg_addr == sync_serial_pkg::OFS_SERIAL_PORT_STATUS);
	assign rd_rx = reg_rd && (reg_addr == sync_serial_pkg::OFS_SERIAL_RECEIVE);
	assign rd_irq_stat = reg_rd && (reg_addr == sync_serial_pkg::OFS_IRQ_STATUS);
	assign tx_write = wr_tx_a || wr_tx_b;
	assign data_access = tx_write || rd_rx;

	// ==========================================================
	// control register
	logic [sync_serial_pkg::DATA_W-1:0] serial_port_control_q;
	logic enable_a_control;
	logic enable_b_control;
	logic any_enable;
	logic [sync_serial_pkg::DIV_SEL_W-1:0] serial_clock_divider_select;

	// a write to the status offset has no decode at all, so it is dropped
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			serial_port_control_q <= sync_serial_pkg::CTRL_RESET;
		end else if (wr_ctrl) begin
			serial_port_control_q <= reg_wdata & sync_serial_pkg::CTRL_WRITE_MASK; // [R5]
		end
	end

	assign enable_a_control = serial_port_control_q[sync_serial_pkg::CTRL_ENABLE_A_BIT];
	assign enable_b_control = serial_port_control_q[sync_serial_pkg::CTRL_ENABLE_B_BIT];
	assign any_enable = enable_a_control || enable_b_control;
	assign serial_clock_divider_select =
		serial_port_control_q[sync_serial_pkg::CTRL_DIV_LSB +: sync_serial_pkg::DIV_SEL_W];

	// ==========================================================
	// enable outputs
	assign serial_enable_a_out = enable_a_control; // [R3]
	assign serial_enable_b_out = enable_b_control && !enable_a_control; // [R2] [R4]

	// ==========================================================
	// transfer engine
	sync_serial_pkg::xfer_state_t state_q;
	logic [BITS-1:0] shift_q;
	logic [BITS-1:0] tx_a_q;
	logic [BITS-1:0] tx_b_q;
	logic [BITS-1:0] rx_q;
	logic [sync_serial_pkg::BIT_CNT_W-1:0] bit_cnt_q;
	logic [sync_serial_pkg::DIV_SEL_W-1:0] div_latched_q;
	logic sclk_q;
	logic drive_q;
	logic busy;
	logic start;
	logic half_tick;
	logic rise_tick;
	logic fall_tick;
	logic last_rise;
	logic [BITS-1:0] start_byte;

	assign busy = (state_q == sync_serial_pkg::st_shift); // [R12] [R13]
	assign start = data_access && any_enable && !busy; // [R16]
	assign rise_tick = half_tick && !sclk_q;
	assign fall_tick = half_tick && sclk_q;
	assign last_rise = rise_tick && (bit_cnt_q == sync_serial_pkg::BIT_CNT_LAST); // [R8]
	// a receive shifts out whatever stays in the register; the line is released then
	assign start_byte = wr_tx_a ? reg_wdata[BITS-1:0] : (wr_tx_b ? reg_wdata[BITS-1:0] : shift_q);

	// divider field is frozen at the start so a control write cannot stretch a bit
	sclk_divider #(
		.SEL_W(sync_serial_pkg::DIV_SEL_W),
		.CNT_W(sync_serial_pkg::DIV_CNT_W)
	) u_div (
		.sys_clk(sys_clk),
		.reset(reset),
		.run(busy),
		.div_sel(div_latched_q),
		.half_tick(half_tick)
	);

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			div_latched_q <= '0;
		end else if (start) begin
			div_latched_q <= serial_clock_divider_select; // [R1]
		end
	end

	// transmit holding registers ignore writes made while busy
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			tx_a_q <= '0;
			tx_b_q <= '0;
		end else begin
			if (wr_tx_a && !busy) begin
				tx_a_q <= reg_wdata[BITS-1:0]; // [R15]
			end
			if (wr_tx_b && !busy) begin
				tx_b_q <= reg_wdata[BITS-1:0]; // [R15]
			end
		end
	end

	// dropping both enables aborts a transfer; nobody is listening any more
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			state_q <= sync_serial_pkg::st_idle;
			bit_cnt_q <= sync_serial_pkg::BIT_CNT_ZERO;
			sclk_q <= 1'b0;
		end else begin
			case (state_q)
				sync_serial_pkg::st_idle: begin
					sclk_q <= 1'b0;
					if (start) begin
						state_q <= sync_serial_pkg::st_shift;
						bit_cnt_q <= sync_serial_pkg::BIT_CNT_ZERO;
					end
				end
				sync_serial_pkg::st_shift: begin
					if (!any_enable) begin
						state_q <= sync_serial_pkg::st_idle;
						sclk_q <= 1'b0;
					end else if (rise_tick) begin
						sclk_q <= 1'b1;
						bit_cnt_q <= sync_serial_pkg::BIT_CNT_W'(bit_cnt_q + sync_serial_pkg::BIT_CNT_ONE);
					end else if (fall_tick) begin
						sclk_q <= 1'b0;
						if (bit_cnt_q == sync_serial_pkg::BIT_CNT_DONE) begin
							state_q <= sync_serial_pkg::st_idle; // [R13]
						end
					end
				end
				default: begin
					state_q <= sync_serial_pkg::st_idle;
					sclk_q <= 1'b0;
				end
			endcase
		end
	end

	// lsb first: data changes on the falling edge, the line is sampled on the rising edge
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			shift_q <= '0;
		end else if (start) begin
			shift_q <= start_byte;
		end else if (busy && rise_tick) begin
			shift_q <= {serial_data_line_in, shift_q[BITS-1:1]};
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			rx_q <= '0;
		end else if (last_rise && any_enable) begin
			rx_q <= {serial_data_line_in, shift_q[BITS-1:1]}; // [R14]
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			drive_q <= 1'b0;
		end else if (start) begin
			drive_q <= tx_write;
		end else if (!busy) begin
			drive_q <= 1'b0;
		end
	end

	// bit 0 of the shifter is the outgoing bit until the rising edge moves it on,
	// so the output is held from a flop copy that only advances on the falling edge
	logic out_bit_q;
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			out_bit_q <= 1'b0;
		end else if (start) begin
			out_bit_q <= start_byte[0];
		end else if (busy && fall_tick) begin
			out_bit_q <= shift_q[0];
		end
	end

	assign serial_clock_out = sclk_q;
	assign serial_data_line_out = out_bit_q;
	assign serial_data_line_oe_n = !(drive_q && busy);

	// ==========================================================
	// status flags
	logic complete_q;
	logic error_q;
	logic error_set;
	logic enable_b_seen_q;
	logic enables_fell;
	logic complete_clear;

	assign error_set = data_access && busy; // [R6]
	assign enables_fell = (enable_b_seen_q || serial_enable_a_out) && !any_enable;
	assign complete_clear = rd_rx || tx_write || rd_status || enables_fell; // [R9] [R11]

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			enable_b_seen_q <= 1'b0;
		end else begin
			enable_b_seen_q <= any_enable;
		end
	end

	// a finishing transfer outranks any clear in the same cycle
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			complete_q <= 1'b0;
		end else if (last_rise && any_enable) begin
			complete_q <= 1'b1; // [R8] [R10]
		end else if (complete_clear) begin
			complete_q <= 1'b0; // [R10]
		end
	end

	// busy can outlast both enables by one cycle; if set and clear meet then, the clear wins
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			error_q <= 1'b0;
		end else if (!any_enable) begin
			error_q <= 1'b0; // [R7]
		end else if (error_set) begin
			error_q <= 1'b1; // [R6]
		end
	end

	// ==========================================================
	// interrupt status and enable
	logic [sync_serial_pkg::IRQ_W-1:0] irq_stat_q;
	logic [sync_serial_pkg::IRQ_W-1:0] irq_en_q;
	logic [sync_serial_pkg::IRQ_W-1:0] irq_events;

	always_comb begin
		irq_events = '0;
		irq_events[sync_serial_pkg::IRQ_COMPLETE_BIT] = last_rise && any_enable;
		irq_events[sync_serial_pkg::IRQ_ERROR_BIT] = error_set;
	end

	// read-to-clear, but an event in the read cycle stays pending
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			irq_stat_q <= sync_serial_pkg::IRQ_RESET;
		end else if (rd_irq_stat) begin
			irq_stat_q <= irq_events;
		end else begin
			irq_stat_q <= irq_stat_q | irq_events;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			irq_en_q <= sync_serial_pkg::IRQ_RESET;
		end else if (wr_irq_en) begin
			irq_en_q <= reg_wdata[sync_serial_pkg::IRQ_W-1:0];
		end
	end

	assign irq = |(irq_stat_q & irq_en_q);

	// ==========================================================
	// read data, one cycle after the strobe; unmapped offsets read zero
	logic [sync_serial_pkg::DATA_W-1:0] rdata_d;
	logic [sync_serial_pkg::DATA_W-1:0] rdata_q;

	always_comb begin
		rdata_d = '0;
		if (reg_rd) begin
			case (reg_addr)
				sync_serial_pkg::OFS_SERIAL_PORT_STATUS: begin
					rdata_d[sync_serial_pkg::STAT_BUSY_BIT] = busy; // [R12]
					rdata_d[sync_serial_pkg::STAT_COMPLETE_BIT] = complete_q;
					rdata_d[sync_serial_pkg::STAT_ERROR_BIT] = error_q;
				end
				sync_serial_pkg::OFS_SERIAL_PORT_CONTROL: begin
					rdata_d = serial_port_control_q;
				end
				sync_serial_pkg::OFS_SERIAL_TRANSMIT_A: begin
					rdata_d[BITS-1:0] = tx_a_q;
				end
				sync_serial_pkg::OFS_SERIAL_TRANSMIT_B: begin
					rdata_d[BITS-1:0] = tx_b_q;
				end
				sync_serial_pkg::OFS_SERIAL_RECEIVE: begin
					rdata_d[BITS-1:0] = rx_q; // [R14]
				end
				sync_serial_pkg::OFS_IRQ_STATUS: begin
					rdata_d[sync_serial_pkg::IRQ_W-1:0] = irq_stat_q;
				end
				sync_serial_pkg::OFS_IRQ_ENABLE: begin
					rdata_d[sync_serial_pkg::IRQ_W-1:0] = irq_en_q;
				end
				default: begin
					rdata_d = '0;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;

endmodule

// [sync_serial_port_properties.sv]
// concurrent checks on the serial port's bus and pins
module sync_serial_port_properties (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic serial_clock_out,
	input wire logic serial_enable_a_out,
	input wire logic serial_enable_b_out,
	input wire logic serial_data_line_oe_n,
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// helpers
	logic [1:0] div_q;
	logic [4:0] hi_q;
	logic en, ctl_wr, st_rd;
	assign en = serial_enable_a_out | serial_enable_b_out;
	assign ctl_wr = reg_wr && reg_addr == 8'h12;
	assign st_rd = reg_rd && reg_addr == 8'h10;
	// divider copy assumes software rewrites it only while idle
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) div_q <= 2'h0;
		else if (ctl_wr) div_q <= reg_wdata[5:4];
	end
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) hi_q <= 5'h0;
		else hi_q <= serial_clock_out ? hi_q + 5'h1 : 5'h0;
	end
	// ==========================================================
	// properties
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	a_enable_a_follow: assert property (ctl_wr |=> serial_enable_a_out == $past(reg_wdata[0]))
		else $error("enable a differs from control bit 0");
	a_enable_b_follow: assert property (ctl_wr |=> serial_enable_b_out == ($past(reg_wdata[1]) && !$past(reg_wdata[0])))
		else $error("enable b differs from control bit 1");
	a_enables_exclusive: assert property (!(serial_enable_a_out && serial_enable_b_out))
		else $error("both enables high");
	a_sclk_half_period: assert property ($fell(serial_clock_out) && en |-> hi_q == (5'h1 << div_q))
		else $error("serial clock high time wrong");
	a_sclk_stops_off: assert property (!en |=> !serial_clock_out)
		else $error("serial clock runs without enable");
	a_drive_needs_enable: assert property (!serial_data_line_oe_n |-> $past(en))
		else $error("data line driven without enable");
	// a driven data line only happens inside a transmit, so it marks a transfer too
	a_status_shows_busy: assert property ($past(st_rd && en && (serial_clock_out || !serial_data_line_oe_n)) |-> reg_rdata[0])
		else $error("busy clear during transfer");
	a_receive_upper_zero: assert property ($past(reg_rd && reg_addr == 8'h18) |-> reg_rdata[15:8] == 8'h00)
		else $error("receive upper bits set");
	a_idle_status_clear: assert property ($past(st_rd && !en) && $past(!en, 2) |-> reg_rdata[2:0] == 3'h0)
		else $error("status not clear with enables off");
	c_complete: cover property ($past(st_rd) && reg_rdata[1]);
	c_error: cover property ($past(st_rd) && reg_rdata[2]);
	c_irq: cover property ($rose(irq));
endmodule

bind sync_serial_port sync_serial_port_properties i_sync_serial_port_properties (.sys_clk, .reset, .reg_addr,
	.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .serial_clock_out, .serial_enable_a_out, .serial_enable_b_out,
	.serial_data_line_oe_n, .irq);

// [tb.sv]
// self-checking bench for the synchronous serial port
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic rd_pend = 1'b0;
	logic [15:0] reg_rdata;
	logic sclk, en_a, en_b, line, d_out, oe_n, irq;
	logic [7:0] reply = 8'h00;
	logic [7:0] heard, b;
	logic [31:0] q_exp[$];
	int failures = 0;
	int tests_run = 0;
	int cycles = 0;
	initial forever #12.5 sys_clk = ~sys_clk;
	sync_serial_port i_sync_serial_port (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_clock_out(sclk),
		.serial_enable_a_out(en_a), .serial_enable_b_out(en_b), .serial_data_line_in(line),
		.serial_data_line_out(d_out), .serial_data_line_oe_n(oe_n), .irq(irq));
	serial_peer i_serial_peer (.sclk(sclk), .sel(en_a | en_b), .port_oe_n(oe_n), .port_out(d_out), .reply(reply),
		.line(line), .heard(heard));
	// ==========================================================
	// bus tasks and checking
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [15:0] m);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		q_exp.push_back({m, e});
		@(posedge sys_clk);
		reg_rd <= 1'b0;
	endtask
	task automatic w(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic end_of_test();
		$display("failures=%0d tests_run=%0d", failures, tests_run);
		if (failures == 0 && tests_run > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// read data stand one cycle after the strobe; look at them mid-cycle
	always @(posedge sys_clk) rd_pend <= reg_rd;
	always @(negedge sys_clk) if (rd_pend) begin
		logic [31:0] n;
		n = q_exp.pop_front();
		chk(reg_rdata & n[31:16], n[15:0]);
	end
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			end_of_test();
		end
	end
	// ==========================================================
	// scenarios
	initial begin
		void'($urandom(32'h6a8a));
		repeat (20) @(posedge sys_clk);
		reset <= 1'b0;
		rd(8'h10, 16'h0000, 16'hffff);
		rd(8'h12, 16'h0000, 16'hffff);
		rd(8'h1e, 16'h0000, 16'hffff);
		wr(8'h10, 16'hffff);
		rd(8'h10, 16'h0000, 16'hffff);
		wr(8'h12, 16'hffff);
		rd(8'h12, 16'h0033, 16'hffff);
		chk({14'h0, en_b, en_a}, 16'h0001);
		wr(8'h12, 16'h0002);
		#1 chk({14'h0, en_b, en_a}, 16'h0002);
		for (int d = 0; d < 4; d++) begin
			b = 8'($urandom);
			wr(8'h12, 16'(d << 4) | 16'h0001);
			wr(8'h16, {8'hff, b});
			#1 chk({15'h0, oe_n}, 16'h0000);
			w((16 << d) + 4);
			rd(8'h10, 16'h0002, 16'h0007);
			rd(8'h10, 16'h0000, 16'h0007);
			chk({8'h00, heard}, {8'h00, b});
		end
		reply <= 8'($urandom);
		wr(8'h12, 16'h0012);
		rd(8'h18, 16'h0000, 16'hff00);
		rd(8'h10, 16'h0001, 16'h0007);
		chk({15'h0, oe_n}, 16'h0001);
		wr(8'h14, 16'h005a);
		w(40);
		rd(8'h10, 16'h0006, 16'h0007);
		rd(8'h18, {8'h00, reply}, 16'hffff);
		rd(8'h10, 16'h0005, 16'h0007);
		w(40);
		wr(8'h1c, 16'h0000);
		#1 chk({15'h0, irq}, 16'h0000);
		wr(8'h1c, 16'h0003);
		#1 chk({15'h0, irq}, 16'h0001);
		rd(8'h1a, 16'h0003, 16'h0003);
		#1 chk({15'h0, irq}, 16'h0000);
		wr(8'h12, 16'h0000);
		rd(8'h10, 16'h0000, 16'h0007);
		wr(8'h12, 16'h0031);
		wr(8'h16, 16'h0055);
		w(20);
		rd(8'h10, 16'h0001, 16'h0007);
		chk({15'h0, oe_n}, 16'h0000);
		wr(8'h12, 16'h0030);
		w(2);
		chk({15'h0, sclk}, 16'h0000);
		rd(8'h10, 16'h0000, 16'h0007);
		wr(8'h16, 16'h00ff);
		rd(8'h10, 16'h0000, 16'h0007);
		// status read lands on the edge of the eighth rise at divide by 2: the set must win
		wr(8'h12, 16'h0001);
		wr(8'h16, 16'h00c3);
		w(13);
		rd(8'h10, 16'h0001, 16'h0007);
		rd(8'h10, 16'h0002, 16'h0007);
		w(3);
		end_of_test();
	end
endmodule
